//--- rtl/dual_timer.sv
// Two multi-function 16-bit timer modules behind one register port.
// Assumes pin inputs and the slow clock are asynchronous to CLK and are synchronised here.
//
// Strobed register access and the register addresses were decided locally.
`timescale 1ns/1ps

////////////////////////////////////////////////////////////////////////////////
// One timer module: pre-scaler, two down counters, two reload/capture registers.
module multi_function_timer
  import timer_pkg::*;
(
  input wire logic clk,
  input wire logic sys_rst,
  input wire reg_req_s req,
  input wire logic sel,
  input wire logic timer_pin_a_in,
  input wire logic timer_pin_b_in,
  input wire logic slow_clk,
  output logic [DATA_W-1:0] rd_value,
  output logic timer_pin_a_out,
  output logic timer_pin_a_oe,
  output logic int_one,
  output logic int_two
);

  // All state of one timer module lives in this struct, so reset and the register stage are one place.
  // The hidden pre-scaler count sits beside the divisor but has no register offset.
  // Synchroniser stages and the previous samples are kept here too, so an edge is seen
  // exactly once however long the pin stays at its new level.
  // Interrupt outputs are registered copies, which keeps them free of glitches from the
  // combinational event decode below.
  typedef struct packed {
    logic [PRE_W-1:0] divisor;
    logic [PRE_W-1:0] pre_count;
    logic [CKS_W-1:0] clk_sel;
    logic [CTRL_W-1:0] ctrl;
    logic [DATA_W-1:0] counter_one;
    logic [DATA_W-1:0] counter_two;
    logic [DATA_W-1:0] reload_capture_a;
    logic [DATA_W-1:0] reload_capture_b;
    logic [3:0] pend;
    logic [3:0] ien;
    logic reload_b;
    logic [1:0] a_sync;
    logic [1:0] b_sync;
    logic [1:0] s_sync;
    logic a_prev;
    logic b_prev;
    logic s_prev;
    logic pin_a_level;
    logic pin_a_oe;
    logic int_one;
    logic int_two;
  } timer_state_s;

  timer_state_s st;
  timer_state_s next_st;

  logic [REG_ADDR_W-1:0] ofs;
  logic wr_hit;
  mode_e mode;
  clk_src_e src_one;
  clk_src_e src_two;
  logic pre_tick;
  logic a_edge;
  logic b_edge;
  logic slow_tick;
  logic b_level_ok;
  logic tick_one;
  logic tick_two;
  logic uf_one;
  logic uf_two;
  logic cap_a;
  logic cap_b;
  logic [3:0] pend_set;
  logic [3:0] pend_clr;

  assign ofs = req.addr[REG_ADDR_W-1:0];
  assign wr_hit = req.wr & sel;
  assign mode = mode_e'(st.ctrl[CTRL_MODE_LSB +: 2]);
  assign src_one = clk_src_e'(st.clk_sel[CKS_ONE_LSB +: 3]);
  assign src_two = clk_src_e'(st.clk_sel[CKS_TWO_LSB +: 3]);

  // Edge events read only the second synchroniser stage and the stage after it.
  // A pin change becomes an event two clocks later, after the two synchroniser stages; the
  // previous-sample stage ends it one clock after. Pulses shorter than one clock may fall between samples.
  assign pre_tick = (st.pre_count == PRESCALE_RESET);
  assign a_edge = st.ctrl[CTRL_A_RISE] ? (st.a_sync[1] & ~st.a_prev)
                                       : (~st.a_sync[1] & st.a_prev);
  assign b_edge = st.ctrl[CTRL_B_RISE] ? (st.b_sync[1] & ~st.b_prev)
                                       : (~st.b_sync[1] & st.b_prev);
  assign slow_tick = st.s_sync[1] & ~st.s_prev;
  assign b_level_ok = (st.b_sync[1] == st.ctrl[CTRL_ACC_LEVEL]);

  // Counter one tick; pin B sources give nothing in dual capture mode.
  // Pin B is a capture input there, so counting its edges would double-book the pin.
  // Counter two keeps every source, which lets it count or time capture events.
  // Codes five to seven fall into the default branch and hold the counter.
  always_comb begin
    case (src_one)
      CLK_PRESCALED: tick_one = pre_tick;
      CLK_EXT_EVENT: tick_one = b_edge & (mode != MODE_DUAL_CAPTURE);
      CLK_PULSE_ACC: tick_one = pre_tick & b_level_ok & (mode != MODE_DUAL_CAPTURE);
      CLK_SLOW: tick_one = slow_tick;
      default: tick_one = 1'b0;
    endcase
  end

  // Counter two tick; every source stays available to it in all modes.
  always_comb begin
    case (src_two)
      CLK_PRESCALED: tick_two = pre_tick;
      CLK_EXT_EVENT: tick_two = b_edge;
      CLK_PULSE_ACC: tick_two = pre_tick & b_level_ok;
      CLK_SLOW: tick_two = slow_tick;
      default: tick_two = 1'b0;
    endcase
  end

  // Underflow is a tick while the count stands at zero.
  // Detecting the wrap before it happens lets the reload replace the FFFF value in the
  // same edge, so the reloaded count never shows an extra cycle.
  assign uf_one = tick_one & (st.counter_one == COUNT_ZERO);
  assign uf_two = tick_two & (st.counter_two == COUNT_ZERO);
  assign cap_a = a_edge & (mode == MODE_DUAL_CAPTURE);
  assign cap_b = b_edge & ((mode == MODE_DUAL_CAPTURE) | (mode == MODE_CAPTURE_TIMER));

  // Hardware events that set pending flags.
  // The meaning of flags A and B changes with the mode; flag D always belongs to counter two.
  // Software must clear stale flags after a mode change, as they keep their old meaning.
  always_comb begin
    pend_set = 4'h0;
    case (mode)
      MODE_PWM: begin
        pend_set[PEND_A] = uf_one & ~st.reload_b;
        pend_set[PEND_B] = uf_one & st.reload_b;
      end
      MODE_DUAL_CAPTURE: begin
        pend_set[PEND_A] = cap_a;
        pend_set[PEND_B] = cap_b;
        pend_set[PEND_C] = uf_one;
      end
      MODE_DUAL_TIMER: begin
        pend_set[PEND_A] = uf_one;
        pend_set[PEND_B] = uf_two;
      end
      MODE_CAPTURE_TIMER: begin
        pend_set[PEND_A] = uf_one;
        pend_set[PEND_B] = cap_b;
      end
      default: pend_set = 4'h0;
    endcase
    pend_set[PEND_D] = uf_two;
  end

  assign pend_clr = (wr_hit && ofs == OFS_PENDING) ? req.wdata[3:0] : 4'h0;

  // Read value for the addressed register; unmapped offsets read zero.
  // The top level registers this value, so the answer appears one clock after the strobe.
  always_comb begin
    rd_value = '0;
    case (ofs)
      OFS_PRESCALE: rd_value = {{(DATA_W-PRE_W){1'b0}}, st.divisor};
      OFS_CLK_SEL: rd_value = {{(DATA_W-CKS_W){1'b0}}, st.clk_sel};
      OFS_CTRL: rd_value = {{(DATA_W-CTRL_W){1'b0}}, st.ctrl};
      OFS_COUNTER_ONE: rd_value = st.counter_one;
      OFS_COUNTER_TWO: rd_value = st.counter_two;
      OFS_RELOAD_A: rd_value = st.reload_capture_a;
      OFS_RELOAD_B: rd_value = st.reload_capture_b;
      OFS_PENDING: rd_value = {12'h000, st.pend};
      OFS_INT_EN: rd_value = {12'h000, st.ien};
      default: rd_value = '0;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Next-state logic for the whole module.
  // The order of the blocks below sets priority: later assignments override earlier ones.
  // Counting comes first, captures and presets next, software writes last.
  // Pending flags and outputs are computed at the end from the settled values.
  always_comb begin
    next_st = st;

    // Synchronisers; the first stage feeds only the second.
    next_st.a_sync = {st.a_sync[0], timer_pin_a_in};
    next_st.b_sync = {st.b_sync[0], timer_pin_b_in};
    next_st.s_sync = {st.s_sync[0], slow_clk};
    next_st.a_prev = st.a_sync[1];
    next_st.b_prev = st.b_sync[1];
    next_st.s_prev = st.s_sync[1];

    // Pre-scaler down counter reloads from the divisor when it reaches zero.
    if (pre_tick) begin
      next_st.pre_count = st.divisor;
    end else begin
      next_st.pre_count = st.pre_count - 5'h01;
    end

    // Counter one and its reload or preset.
    // Reloading on the underflow tick itself keeps the period at the reload value plus one
    // tick, which is what the PWM high and low times are built from.
    if (uf_one) begin
      case (mode)
        MODE_PWM: begin
          next_st.counter_one = st.reload_b ? st.reload_capture_b : st.reload_capture_a;
          next_st.reload_b = ~st.reload_b;
        end
        MODE_DUAL_TIMER, MODE_CAPTURE_TIMER: next_st.counter_one = st.reload_capture_a;
        default: next_st.counter_one = COUNT_PRESET;
      endcase
      if (st.ctrl[CTRL_TOGGLE_EN] && mode != MODE_DUAL_CAPTURE) begin
        next_st.pin_a_level = ~st.pin_a_level;
      end
    end else if (tick_one) begin
      next_st.counter_one = st.counter_one - 16'h0001;
    end

    // Captures store the old count first, then an enabled preset loads FFFF; preset B acts in dual capture mode only.
    // A preset overrides a tick in the same cycle, so the preset count is never decremented
    // before software has a chance to see it.
    if (cap_a) begin
      next_st.reload_capture_a = st.counter_one;
      if (st.ctrl[CTRL_PRESET_A]) begin
        next_st.counter_one = COUNT_PRESET;
      end
    end
    if (cap_b) begin
      next_st.reload_capture_b = st.counter_one;
      if (st.ctrl[CTRL_PRESET_B] && mode == MODE_DUAL_CAPTURE) begin
        next_st.counter_one = COUNT_PRESET;
      end
    end

    // Counter two reloads from B only in dual timer mode, else wraps.
    // In the other modes register B is a capture destination or the second PWM time,
    // so reloading from it there would tie counter two to an unrelated value.
    if (uf_two) begin
      next_st.counter_two = (mode == MODE_DUAL_TIMER) ? st.reload_capture_b : COUNT_PRESET;
    end else if (tick_two) begin
      next_st.counter_two = st.counter_two - 16'h0001;
    end

    // Selecting CLK_NONE for counter one or leaving PWM mode restarts the A-first sequence.
    if (mode != MODE_PWM || src_one == CLK_NONE) begin
      next_st.reload_b = 1'b0;
    end

    // Software writes take priority over hardware updates of the same register, except the pending flags.
    // A write that meets a capture in the same cycle therefore loses the captured value;
    // software that writes a capture register must accept that trade.
    if (wr_hit) begin
      case (ofs)
        OFS_PRESCALE: next_st.divisor = req.wdata[PRE_W-1:0];
        OFS_CLK_SEL: next_st.clk_sel = req.wdata[CKS_W-1:0];
        OFS_CTRL: begin
          next_st.ctrl = req.wdata[CTRL_W-1:0];
          next_st.pin_a_level = req.wdata[CTRL_INIT_LEVEL];
          if (req.wdata[CTRL_MODE_LSB +: 2] != st.ctrl[CTRL_MODE_LSB +: 2]) begin
            next_st.reload_b = 1'b0;
          end
        end
        OFS_COUNTER_ONE: next_st.counter_one = req.wdata;
        OFS_COUNTER_TWO: next_st.counter_two = req.wdata;
        OFS_RELOAD_A: next_st.reload_capture_a = req.wdata;
        OFS_RELOAD_B: next_st.reload_capture_b = req.wdata;
        OFS_INT_EN: next_st.ien = req.wdata[3:0];
        default: next_st.ien = st.ien;
      endcase
    end

    // Pending flags: a set in the same cycle as a clear wins.
    next_st.pend = (st.pend & ~pend_clr) | pend_set;

    // Pin A drives whenever toggling is enabled, in every mode but dual capture.
    next_st.pin_a_oe = (mode != MODE_DUAL_CAPTURE) & st.ctrl[CTRL_TOGGLE_EN];

    // Interrupt one collects flags A and C, interrupt two flags B and D.
    // The enable mask is the registered one, so a newly written enable takes effect
    // one clock later than the flag it gates.
    next_st.int_one = |(next_st.pend & st.ien & 4'h5);
    next_st.int_two = |(next_st.pend & st.ien & 4'hA);
  end

  // State register; nothing moves while CLK is halted, slow ticks included.
  // A slow-clock edge that arrives while CLK is stopped is lost rather than queued,
  // so counts taken across a clock halt run short by those ticks.
  // Reset is synchronous, so CLK must run while it is held.
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign timer_pin_a_out = st.pin_a_level;
  assign timer_pin_a_oe = st.pin_a_oe;
  assign int_one = st.int_one;
  assign int_two = st.int_two;

endmodule : multi_function_timer

////////////////////////////////////////////////////////////////////////////////
// Top level: two timer modules; address bit four picks the module.
// Both modules share the write port; the select decode keeps a write from landing in both.
// Read data from the unselected module are simply not routed.
module dual_timer
  import timer_pkg::*;
#(
  parameter int MODULES = 2
)
(
  input wire logic CLK,
  input wire logic SYS_RST,
  input wire logic [ADDR_W-1:0] ADDR,
  input wire logic [DATA_W-1:0] WDATA,
  input wire logic WR,
  input wire logic RD,
  output logic [DATA_W-1:0] RDATA,
  input wire logic [MODULES-1:0] TIMER_PIN_A_IN,
  output logic [MODULES-1:0] TIMER_PIN_A_OUT,
  output logic [MODULES-1:0] TIMER_PIN_A_OE,
  input wire logic [MODULES-1:0] TIMER_PIN_B_IN,
  input wire logic SLOW_CLK,
  output logic [MODULES-1:0] INT_TIMER_ONE,
  output logic [MODULES-1:0] INT_TIMER_TWO
);

  typedef struct packed {
    logic [DATA_W-1:0] rdata;
  } top_state_s;

  top_state_s st;
  top_state_s next_st;
  reg_req_s req;
  logic [DATA_W-1:0] rd_value [MODULES];

  assign req = '{addr: ADDR, wdata: WDATA, wr: WR, rd: RD};

  // One module instance per index; each keeps its own registers and pins.
  // Only bit zero of the index reaches the select, so more than two modules would alias.
  for (genvar m = 0; m < MODULES; m++) begin : g_timer
    multi_function_timer u_timer (
      .clk(CLK),
      .sys_rst(SYS_RST),
      .req(req),
      .sel(ADDR[MOD_SEL_BIT] == 1'(m)),
      .timer_pin_a_in(TIMER_PIN_A_IN[m]),
      .timer_pin_b_in(TIMER_PIN_B_IN[m]),
      .slow_clk(SLOW_CLK),
      .rd_value(rd_value[m]),
      .timer_pin_a_out(TIMER_PIN_A_OUT[m]),
      .timer_pin_a_oe(TIMER_PIN_A_OE[m]),
      .int_one(INT_TIMER_ONE[m]),
      .int_two(INT_TIMER_TWO[m])
    );
  end

  // Read data stand only in the cycle after the read strobe.
  // Holding zero otherwise keeps the shared read bus quiet between reads.
  // The module is picked by the address of the strobe cycle, not a later one.
  always_comb begin
    next_st.rdata = '0;
    if (RD) begin
      next_st.rdata = rd_value[ADDR[MOD_SEL_BIT]];
    end
  end

  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign RDATA = st.rdata;

endmodule : dual_timer

//--- rtl/timer_pkg.sv
// Constants, types and register map of the dual multi-function timer.
// Assumes one system clock with a synchronous active-high reset and a plain register port.
package timer_pkg;

  localparam int DATA_W = 16;
  localparam int REG_ADDR_W = 4;
  localparam int ADDR_W = 5;
  localparam int PRE_W = 5;
  localparam int MOD_SEL_BIT = 4;

  // Register offsets inside one timer module.
  localparam logic [REG_ADDR_W-1:0] OFS_PRESCALE = 4'h0;
  localparam logic [REG_ADDR_W-1:0] OFS_CLK_SEL = 4'h1;
  localparam logic [REG_ADDR_W-1:0] OFS_CTRL = 4'h2;
  localparam logic [REG_ADDR_W-1:0] OFS_COUNTER_ONE = 4'h3;
  localparam logic [REG_ADDR_W-1:0] OFS_COUNTER_TWO = 4'h4;
  localparam logic [REG_ADDR_W-1:0] OFS_RELOAD_A = 4'h5;
  localparam logic [REG_ADDR_W-1:0] OFS_RELOAD_B = 4'h6;
  localparam logic [REG_ADDR_W-1:0] OFS_PENDING = 4'h7;
  localparam logic [REG_ADDR_W-1:0] OFS_INT_EN = 4'h8;

  // Control register fields.
  localparam int CTRL_W = 9;
  localparam int CTRL_MODE_LSB = 0;
  localparam int CTRL_A_RISE = 2;
  localparam int CTRL_B_RISE = 3;
  localparam int CTRL_PRESET_A = 4;
  localparam int CTRL_PRESET_B = 5;
  localparam int CTRL_TOGGLE_EN = 6;
  localparam int CTRL_INIT_LEVEL = 7;
  localparam int CTRL_ACC_LEVEL = 8;

  // Clock select fields, three bits per counter.
  localparam int CKS_W = 6;
  localparam int CKS_ONE_LSB = 0;
  localparam int CKS_TWO_LSB = 3;

  // Pending flag positions.
  localparam int PEND_A = 0;
  localparam int PEND_B = 1;
  localparam int PEND_C = 2;
  localparam int PEND_D = 3;

  // Reset values and fixed counter values.
  localparam logic [PRE_W-1:0] PRESCALE_RESET = 5'h00;
  localparam logic [DATA_W-1:0] COUNT_RESET = 16'h0000;
  localparam logic [DATA_W-1:0] COUNT_ZERO = 16'h0000;
  localparam logic [DATA_W-1:0] COUNT_PRESET = 16'hFFFF;

  typedef enum logic [2:0] {
    CLK_NONE,
    CLK_PRESCALED,
    CLK_EXT_EVENT,
    CLK_PULSE_ACC,
    CLK_SLOW
  } clk_src_e;

  typedef enum logic [1:0] {
    MODE_PWM,
    MODE_DUAL_CAPTURE,
    MODE_DUAL_TIMER,
    MODE_CAPTURE_TIMER
  } mode_e;

  // One register port request.
  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic wr;
    logic rd;
  } reg_req_s;

endpackage : timer_pkg

//--- tb/dual_timer_monitor.sv
// Checker for the dual timer: read port, pin A enable and interrupt gating of module zero.
// Assumes it is bound into dual_timer and sees only that module's ports.
`timescale 1ns/1ps
module dual_timer_monitor
  import timer_pkg::*;
#(
  parameter int MODULES = 2
)
(
  input wire logic CLK,
  input wire logic SYS_RST,
  input wire logic [ADDR_W-1:0] ADDR,
  input wire logic [DATA_W-1:0] WDATA,
  input wire logic WR,
  input wire logic RD,
  input wire logic [DATA_W-1:0] RDATA,
  input wire logic [MODULES-1:0] TIMER_PIN_A_IN,
  input wire logic [MODULES-1:0] TIMER_PIN_A_OUT,
  input wire logic [MODULES-1:0] TIMER_PIN_A_OE,
  input wire logic [MODULES-1:0] TIMER_PIN_B_IN,
  input wire logic SLOW_CLK,
  input wire logic [MODULES-1:0] INT_TIMER_ONE,
  input wire logic [MODULES-1:0] INT_TIMER_TWO
);
  logic [4:0] div_sh;
  logic [8:0] ctl_sh;
  logic [3:0] ien_sh;
  logic [1:0] ctl_age;
  logic [1:0] ien_age;
  logic [2:0] wr_hist;
  logic wr0;

  assign wr0 = WR && !ADDR[MOD_SEL_BIT];

  ////////////////////////////////////////////////////////////
  // Shadows of software-owned registers; ages give the design time to settle its outputs.
  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      div_sh <= 5'h00;
      ctl_sh <= 9'h000;
      ien_sh <= 4'h0;
      ctl_age <= 2'h0;
      ien_age <= 2'h0;
      wr_hist <= 3'h0;
    end else begin
      wr_hist <= {wr_hist[1:0], wr0};
      if (ctl_age != 2'h3) ctl_age <= ctl_age + 2'h1;
      if (ien_age != 2'h3) ien_age <= ien_age + 2'h1;
      if (wr0 && ADDR[3:0] == OFS_PRESCALE) div_sh <= WDATA[4:0];
      if (wr0 && ADDR[3:0] == OFS_CTRL) begin
        ctl_sh <= WDATA[8:0];
        ctl_age <= 2'h0;
      end
      if (wr0 && ADDR[3:0] == OFS_INT_EN) begin
        ien_sh <= WDATA[3:0];
        ien_age <= 2'h0;
      end
    end
  end

  default clocking cb @(posedge CLK); endclocking
  default disable iff (SYS_RST);

  a_rd_idle: assert property (!RD |=> RDATA == 16'h0000)
    else $error("read data not zero outside a read answer");
  a_div_back: assert property (RD && ADDR == 5'h00 |=> RDATA == {11'h000, $past(div_sh)})
    else $error("divisor read back wrong");
  a_ctl_back: assert property (RD && ADDR == 5'h02 |=> RDATA == {7'h00, $past(ctl_sh)})
    else $error("control read back wrong");
  a_gap_zero: assert property (RD && ADDR[3:0] > OFS_INT_EN |=> RDATA == 16'h0000)
    else $error("unmapped offset read not zero");
  a_pend_width: assert property (RD && ADDR[3:0] == OFS_PENDING |=> RDATA[15:4] == 12'h000)
    else $error("pending read has upper bits");
  a_pin_enable: assert property (ctl_age == 2'h3 |-> TIMER_PIN_A_OE[0] == (ctl_sh[6] && ctl_sh[1:0] != 2'h1))
    else $error("pin A enable disagrees with control");
  a_int_gated: assert property (ien_age == 2'h3 |-> (!INT_TIMER_ONE[0] || ien_sh[0] || ien_sh[2]))
    else $error("interrupt one high while disabled");
  a_int_sticky: assert property ($fell(INT_TIMER_ONE[0]) || $fell(INT_TIMER_TWO[0]) |-> wr_hist != 3'h0)
    else $error("interrupt dropped without a write");

  c_pin_drive: cover property ($rose(TIMER_PIN_A_OE[0]));
  c_int_one: cover property ($rose(INT_TIMER_ONE[0]));
  c_int_two: cover property ($rose(INT_TIMER_TWO[0]));
endmodule : dual_timer_monitor

bind dual_timer dual_timer_monitor #(.MODULES(MODULES)) i_dual_timer_monitor (
  .CLK(CLK), .SYS_RST(SYS_RST), .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD), .RDATA(RDATA),
  .TIMER_PIN_A_IN(TIMER_PIN_A_IN), .TIMER_PIN_A_OUT(TIMER_PIN_A_OUT), .TIMER_PIN_A_OE(TIMER_PIN_A_OE),
  .TIMER_PIN_B_IN(TIMER_PIN_B_IN), .SLOW_CLK(SLOW_CLK), .INT_TIMER_ONE(INT_TIMER_ONE),
  .INT_TIMER_TWO(INT_TIMER_TWO)
);

//--- tb/pin_drive_model.sv
// Far side of the timer pins: drives pins A and B of module zero and the slow clock; module one's pins stay low.
// Assumes its tasks are called by the bench just after a rising edge of clk.
`timescale 1ns/1ps
module pin_drive_model
#(
  parameter int SLOW_HALF = 305
)
(
  input wire logic clk,
  output logic [1:0] pin_a,
  output logic [1:0] pin_b,
  output logic slow_clk
);
  initial begin
    pin_a = 2'h0;
    pin_b = 2'h0;
    slow_clk = 1'b0;
  end

  ////////////////////////////////////////////////////////////
  // The slow clock runs free far below a quarter of CLK, so sampling never misses it.
  always begin
    repeat (SLOW_HALF) @(posedge clk);
    slow_clk <= ~slow_clk;
  end

  // A level is held for n cycles, at least one, so no edge is too short to see.
  task automatic drive_b(input logic v, input int n);
    @(posedge clk);
    pin_b[0] <= v;
    repeat (n) @(posedge clk);
  endtask : drive_b

  task automatic drive_a(input logic v, input int n);
    @(posedge clk);
    pin_a[0] <= v;
    repeat (n) @(posedge clk);
  endtask : drive_a
endmodule : pin_drive_model

//--- tb/test_dual_timer.sv
// Self-checking bench for the dual timer, module zero mostly, module one for separation.
// Assumes pin_drive_model drives the pins; the wire of pin A is resolved here.
`timescale 1ns/1ps
module test_dual_timer;
  import timer_pkg::*;
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  logic [ADDR_W-1:0] addr = 5'h00;
  logic [DATA_W-1:0] wdata = 16'h0000;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [DATA_W-1:0] rdata;
  logic [1:0] pin_a_out, pin_a_oe, pin_a_drv, pin_a, pin_b, int_one, int_two;
  logic slow_clk;
  logic [DATA_W-1:0] v;
  logic [DATA_W-1:0] w;
  int mismatches = 0;
  int cmp_count = 0;

  always #25 clk = ~clk;
  // Pin A carries the design's level while it drives, otherwise the model's.
  assign pin_a = (pin_a_oe & pin_a_out) | (~pin_a_oe & pin_a_drv);

  dual_timer i_dual_timer (
    .CLK(clk), .SYS_RST(sys_rst), .ADDR(addr), .WDATA(wdata), .WR(wr), .RD(rd), .RDATA(rdata),
    .TIMER_PIN_A_IN(pin_a), .TIMER_PIN_A_OUT(pin_a_out), .TIMER_PIN_A_OE(pin_a_oe),
    .TIMER_PIN_B_IN(pin_b), .SLOW_CLK(slow_clk), .INT_TIMER_ONE(int_one), .INT_TIMER_TWO(int_two)
  );
  pin_drive_model i_pin_drive_model (.clk(clk), .pin_a(pin_a_drv), .pin_b(pin_b), .slow_clk(slow_clk));

  ////////////////////////////////////////////////////////////
  task automatic chk(input string what, input logic [15:0] got, input logic [15:0] exp);
    cmp_count++;
    if (got !== exp) begin
      mismatches++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  // Bus cycles end with the strobe low, so the next one always starts an edge later.
  task automatic wreg(input logic m, input logic [3:0] o, input logic [15:0] d);
    @(posedge clk);
    addr <= {m, o};
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask : wreg

  task automatic rreg(input logic m, input logic [3:0] o, output logic [15:0] d);
    @(posedge clk);
    addr <= {m, o};
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 d = rdata;
  endtask : rreg

  // Two reads of counter two exactly n cycles apart; any such window holds a fixed tick count.
  task automatic step(input int n, input logic [15:0] dec);
    rreg(1'b0, OFS_COUNTER_TWO, v);
    repeat (n - 2) @(posedge clk);
    rreg(1'b0, OFS_COUNTER_TWO, w);
    chk("count step", v - w, dec);
  endtask : step

  task automatic t_regs;
    rreg(1'b0, OFS_PRESCALE, v);
    chk("divisor reset", v, 16'h0000);
    wreg(1'b0, OFS_PRESCALE, 16'hFFFF);
    wreg(1'b1, OFS_PRESCALE, 16'h000A);
    rreg(1'b0, OFS_PRESCALE, v);
    chk("divisor width", v, 16'h001F);
    rreg(1'b1, OFS_PRESCALE, v);
    chk("second module", v, 16'h000A);
    rreg(1'b0, 4'hC, v);
    chk("unmapped", v, 16'h0000);
  endtask : t_regs

  // The old divisor's period is allowed to run out before the window opens.
  task automatic t_rate(input logic [4:0] d, input int n, input logic [15:0] dec);
    wreg(1'b0, OFS_PRESCALE, {11'h000, d});
    repeat (40) @(posedge clk);
    wreg(1'b0, OFS_COUNTER_TWO, 16'h8000);
    step(n, dec);
  endtask : t_rate

  task automatic t_event;
    wreg(1'b0, OFS_CTRL, 16'h000A);
    wreg(1'b0, OFS_RELOAD_B, 16'h0005);
    wreg(1'b0, OFS_INT_EN, 16'h0008);
    wreg(1'b0, OFS_CLK_SEL, 16'h0010);
    wreg(1'b0, OFS_COUNTER_TWO, 16'h0000);
    i_pin_drive_model.drive_b(1'b1, 6);
    rreg(1'b0, OFS_COUNTER_TWO, v);
    chk("reload two", v, 16'h0005);
    chk("int two", {15'h0000, int_two[0]}, 16'h0001);
    chk("module one quiet", {12'h000, int_one[1], int_two[1], pin_a_out[1], pin_a_oe[1]}, 16'h0000);
    i_pin_drive_model.drive_b(1'b0, 6);
    rreg(1'b0, OFS_COUNTER_TWO, v);
    chk("falling ignored", v, 16'h0005);
    rreg(1'b0, OFS_PENDING, v);
    chk("pending", v, 16'h000A);
    wreg(1'b0, OFS_PENDING, 16'h000F);
    rreg(1'b0, OFS_PENDING, v);
    chk("pending clear", v, 16'h0000);
  endtask : t_event

  task automatic t_pwm;
    int t;
    int gap [3];
    wreg(1'b0, OFS_CLK_SEL, 16'h0000);
    wreg(1'b0, OFS_RELOAD_A, 16'h0003);
    wreg(1'b0, OFS_RELOAD_B, 16'h0007);
    wreg(1'b0, OFS_PRESCALE, 16'h0000);
    wreg(1'b0, OFS_COUNTER_ONE, 16'h0000);
    wreg(1'b0, OFS_CTRL, 16'h00C0);
    wreg(1'b0, OFS_CLK_SEL, 16'h0001);
    chk("initial level", {15'h0000, pin_a_out[0]}, 16'h0001);
    for (int i = 0; i < 3; i++) begin
      w[0] = pin_a_out[0];
      t = 0;
      while (pin_a_out[0] === w[0] && t < 50) begin
        @(posedge clk);
        #1 t++;
      end
      gap[i] = t;
    end
    chk("pin A enable", {15'h0000, pin_a_oe[0]}, 16'h0001);
    chk("time from A", 16'(gap[1]), 16'h0004);
    chk("time from B", 16'(gap[2]), 16'h0008);
  endtask : t_pwm

  task automatic t_capture;
    wreg(1'b0, OFS_CLK_SEL, 16'h0002);
    wreg(1'b0, OFS_CTRL, 16'h001D);
    rreg(1'b0, OFS_CTRL, v);
    chk("control", v, 16'h001D);
    wreg(1'b0, OFS_PENDING, 16'h000F);
    wreg(1'b0, OFS_INT_EN, 16'h0001);
    wreg(1'b0, OFS_COUNTER_ONE, 16'h1234);
    i_pin_drive_model.drive_b(1'b1, 6);
    i_pin_drive_model.drive_b(1'b0, 6);
    rreg(1'b0, OFS_COUNTER_ONE, v);
    chk("event source stopped", v, 16'h1234);
    rreg(1'b0, OFS_RELOAD_B, v);
    chk("capture B", v, 16'h1234);
    i_pin_drive_model.drive_a(1'b1, 6);
    rreg(1'b0, OFS_RELOAD_A, v);
    chk("capture A", v, 16'h1234);
    rreg(1'b0, OFS_COUNTER_ONE, v);
    chk("preset", v, 16'hFFFF);
    chk("int one", {15'h0000, int_one[0]}, 16'h0001);
    i_pin_drive_model.drive_a(1'b0, 6);
  endtask : t_capture

  task automatic t_other;
    wreg(1'b0, OFS_CTRL, 16'h0102);
    wreg(1'b0, OFS_CLK_SEL, 16'h0018);
    wreg(1'b0, OFS_COUNTER_TWO, 16'h4000);
    i_pin_drive_model.drive_b(1'b1, 8);
    step(20, 16'h0014);
    i_pin_drive_model.drive_b(1'b0, 8);
    step(20, 16'h0000);
    wreg(1'b0, OFS_CLK_SEL, 16'h0020);
    step(610, 16'h0001);
    wreg(1'b0, OFS_CLK_SEL, 16'h0000);
    step(20, 16'h0000);
    wreg(1'b0, OFS_CTRL, 16'h000B);
    wreg(1'b0, OFS_COUNTER_ONE, 16'h0777);
    i_pin_drive_model.drive_b(1'b1, 6);
    rreg(1'b0, OFS_RELOAD_B, v);
    chk("mode four capture", v, 16'h0777);
  endtask : t_other

  task automatic end_sim;
    $display("compares %0d mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : end_sim

  ////////////////////////////////////////////////////////////
  // The run needs about eleven hundred cycles; the watchdog allows some eighteen times that.
  initial begin
    repeat (20000) @(posedge clk);
    mismatches++;
    end_sim();
  end

  initial begin
    repeat (10) @(posedge clk);
    sys_rst <= 1'b0;
    t_regs();
    wreg(1'b0, OFS_CTRL, 16'h0002);
    wreg(1'b0, OFS_CLK_SEL, 16'h0008);
    t_rate(5'h00, 40, 16'h0028);
    t_rate(5'h03, 40, 16'h000A);
    t_rate(5'h1F, 64, 16'h0002);
    t_event();
    t_pwm();
    t_capture();
    t_other();
    end_sim();
  end
endmodule : test_dual_timer
